// ### bench/eppgi_host_model.sv
module eppgi_host_model
    import eppgi_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bus drive
    output logic ctrlSpaceSel,
    output logic portSpaceSel,
    output logic [5:0] addr,
    output logic wrStrobe,
    output logic rdStrobe,
    output logic [31:0] wdata,
    // Bus answer
    input wire logic [31:0] rdata,
    input wire logic rdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////
    // Idle bus at time zero
    initial
    begin
        {ctrlSpaceSel, portSpaceSel, wrStrobe, rdStrobe} = 4'h0;
        addr = 6'h00;
        wdata = 32'h0;
    end
    // One access; one idle cycle apart so no line moves twice at once
    task automatic acc(input logic w, c, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        {ctrlSpaceSel, portSpaceSel, wrStrobe, rdStrobe} = {c, !c, w, !w};
        addr = a;
        wdata = d;
        @(negedge clk);
        q = rdValid ? rdata : 32'hX;
        {ctrlSpaceSel, portSpaceSel, wrStrobe, rdStrobe} = 4'h0;
        addr = ~a;
        wdata = ~d;
    endtask
    // Service on, rising polarity, both flags cleared
    task automatic ack();
        logic [31:0] q;
        acc(1'b1, 1'b1, OFF_INT_CTRL_STATUS, 32'h00821000,
            q);
    endtask
endmodule

// ### bench/eppgi_top_monitor.sv
module eppgi_top_monitor
    import eppgi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register access
    input wire logic ctrlSpaceSel,
    input wire logic portSpaceSel,
    input wire logic [5:0] addr,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [31:0] rdata,
    input wire logic rdValid,
    // Pins and request
    input wire logic [95:0] portIn,
    input wire logic [95:0] portOe,
    input wire logic irqReq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////
    // Decodes; both selects high together is never driven
    wire logic ctlHit;
    wire logic prtRd;
    assign ctlHit = ctrlSpaceSel && !portSpaceSel
        && addr == OFF_INT_CTRL_STATUS;
    assign prtRd = rdStrobe && portSpaceSel && !ctrlSpaceSel;
    // Read answers, one cycle late
    property p_rd_ans; rdStrobe |=> rdValid; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read not answered");
    property p_no_ans; !rdStrobe |=> !rdValid; endproperty
    a_no_ans: assert property (p_no_ans)
        else $error("answer without read");
    property p_top; prtRd |=> rdata[31:28] == 4'h0; endproperty
    a_top: assert property (p_top)
        else $error("group word top bits set");
    property p_unmap; prtRd && addr >= 6'h10 |=> rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("port hole read nonzero");
    property p_rsvd;
        rdStrobe && ctlHit |=> (rdata & ~32'h00821040) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bit set");
    // Whole A byte, C split in nibbles only
    property p_dir;
        portOe[7:0] inside {8'h00, 8'hFF}
            && portOe[19:16] inside {4'h0, 4'hF};
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction split wrongly");
    // Request rises only after a synced pin change
    property p_cause;
        $rose(irqReq) |-> $past(portIn[94], 3) != $past(portIn[94], 4);
    endproperty
    a_cause: assert property (p_cause)
        else $error("request without pin edge");
    property p_hold; irqReq && !(wrStrobe && ctlHit) |=> irqReq;
    endproperty
    a_hold: assert property (p_hold)
        else $error("request dropped uncleared");
endmodule
bind eppgi_top eppgi_top_monitor i_mon (.clk, .arst_n, .ctrlSpaceSel,
    .portSpaceSel, .addr, .wrStrobe, .rdStrobe, .rdata, .rdValid,
    .portIn, .portOe, .irqReq);

// ### bench/tb_top.sv
module tb_top
    import eppgi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, ctrlSpaceSel, portSpaceSel, wrStrobe, rdStrobe;
    logic rdValid, mapSelJumper, irqReq;
    logic [5:0] addr;
    logic [31:0] wdata, rdata, q, w;
    logic [95:0] portIn, portOut, portOe;
    int errCount = 0;
    int totalChecks = 0;
    ////////////////////////////////
    // Device and its host
    eppgi_top i_dut (.clk, .arst_n, .ctrlSpaceSel, .portSpaceSel, .addr,
        .wrStrobe, .rdStrobe, .wdata, .rdata, .rdValid, .mapSelJumper,
        .portIn, .portOut, .portOe, .irqReq);
    eppgi_host_model i_host (.clk, .ctrlSpaceSel, .portSpaceSel, .addr,
        .wrStrobe, .rdStrobe, .wdata, .rdata, .rdValid);
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Checking and verdict
    task automatic chk(input logic [95:0] got, exp);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finalReport();
        $display("checks %0d errors %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [23:0] oeOf(input logic [3:0] d);
        return {{4{d[3]}}, {4{d[2]}}, {8{d[1]}}, {8{d[0]}}};
    endfunction
    // Bus shorthands
    task automatic wr(input logic c, input logic [5:0] a,
        input logic [31:0] d);
        i_host.acc(1'b1, c, a, d, q);
    endtask
    task automatic rd(input logic c, input logic [5:0] a,
        input logic [31:0] e);
        i_host.acc(1'b0, c, a, 32'h0, q);
        chk(q, e);
    endtask
    // Pin move, then two sync stages and the edge compare
    task automatic pulseReq(input logic v);
        portIn[94] = v;
        repeat (4) @(negedge clk);
    endtask
    // Hang guard, far beyond the expected run
    initial
    begin
        #(25 * 4000);
        errCount++;
        finalReport();
    end
    // Main sequence
    initial
    begin
        logic [23:0] m, pin;
        logic [95:0] o;
        int g;
        void'($urandom(32'h0B75));
        arst_n = 1'b0;
        mapSelJumper = 1'b0;
        portIn = 96'h0;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        rd(1'b1, OFF_INT_CTRL_STATUS, 32'h0);
        // Random words, first two with split directions
        for (int i = 0; i < 12; i++)
        begin
            g = i % GROUPS;
            w = $urandom & 32'h0FFFFFFF;
            if (i < 2)
                w[27:24] = i ? 4'hA : 4'h5;
            pin = 24'($urandom);
            m = oeOf(w[27:24]);
            portIn[24 * g +: 24] = pin;
            wr(1'b0, 6'(4 * g), w);
            repeat (2) @(negedge clk);
            chk(portOut[24 * g +: 24], w[23:0]);
            chk(portOe[24 * g +: 24], m);
            w[23:0] = w[23:0] & m | pin & ~m;
            rd(1'b0, 6'(4 * g), w);
        end
        // Holes: writes dropped, reads zero
        o = portOut;
        wr(1'b0, 6'h10, 32'h00FFFFFF);
        chk(portOut, o);
        rd(1'b0, 6'h1C, 32'h0);
        rd(1'b1, 6'h3C, 32'h0);
        rd(1'b1, 6'h00, 32'h0);
        mapSelJumper = 1'b1;
        repeat (3) @(negedge clk);
        rd(1'b0, OFF_GROUP3, 32'h0);
        mapSelJumper = 1'b0;
        repeat (3) @(negedge clk);
        // Interrupts on group 3, all inputs, enable pin low
        wr(1'b0, OFF_GROUP3, 32'h0);
        portIn[95:94] = 2'h0;
        i_host.ack();
        pulseReq(1'b1);
        chk(irqReq, 1'b1);
        rd(1'b1, OFF_INT_CTRL_STATUS, 32'h00021000);
        // Latched inputs must not follow the pins in interrupt mode
        pin = portIn[95:72];
        portIn[93:72] = ~portIn[93:72];
        repeat (3) @(negedge clk);
        rd(1'b0, OFF_GROUP3, {8'h00, pin});
        pulseReq(1'b0);
        pulseReq(1'b1);
        pulseReq(1'b0);
        pulseReq(1'b1);
        rd(1'b1, OFF_INT_CTRL_STATUS, 32'h00821000);
        rd(1'b0, OFF_GROUP3, {8'h00, pin});
        i_host.ack();
        rd(1'b1, OFF_INT_CTRL_STATUS, 32'h00001000);
        chk(irqReq, 1'b0);
        portIn[95] = 1'b1;
        pulseReq(1'b0);
        pulseReq(1'b1);
        chk(irqReq, 1'b0);
        portIn[95] = 1'b0;
        // Falling polarity, then everything off
        wr(1'b1, OFF_INT_CTRL_STATUS, 32'h00001040);
        pulseReq(1'b0);
        rd(1'b1, OFF_INT_CTRL_STATUS, 32'h00021040);
        wr(1'b1, OFF_INT_CTRL_STATUS, 32'h00820000);
        rd(1'b1, OFF_INT_CTRL_STATUS, 32'h0);
        pulseReq(1'b1);
        pulseReq(1'b0);
        chk(irqReq, 1'b0);
        finalReport();
    end
endmodule

// ### src/eppgi_group.sv
module eppgi_group
    import eppgi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register write
    input wire logic wrEn,
    input wire logic [31:0] wdata,
    // Terminals
    input wire logic [23:0] pinIn,
    output logic [23:0] pinOut,
    output logic [23:0] pinOe,
    // State for the read path
    output logic [23:0] dataReg,
    output logic [3:0] dirReg,
    output logic [23:0] syncIn
);
    logic [23:0] metaReg;
    logic [23:0] oeNext;
    logic [3:0] dirNext;

    ////////////////////////////////////////////////////////////////////////
    // Direction fan-out: A and B as whole bytes, C split in nibbles
    assign dirNext = wdata[FLD_DIR_LSB +: DIR_W];
    assign oeNext = {{4{dirNext[DIR_C_HIGH]}}, {4{dirNext[DIR_C_LOW]}},
        {8{dirNext[DIR_B]}}, {8{dirNext[DIR_A]}}};

    // Data and direction storage, shadow oe kept as its own flop
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dataReg <= RST_GROUP_DATA;
            dirReg <= RST_GROUP_DIR;
            pinOe <= {GROUP_W{1'b0}};
        end
        else if (wrEn)
        begin
            dataReg <= wdata[23:0];
            dirReg <= dirNext;
            pinOe <= oeNext;
        end
    end

    // Output bits drive the written data
    assign pinOut = dataReg;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser; only the second stage is read outside
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            metaReg <= {GROUP_W{1'b0}};
            syncIn <= {GROUP_W{1'b0}};
        end
        else
        begin
            metaReg <= pinIn;
            syncIn <= metaReg;
        end
    end
endmodule

// ### src/eppgi_pkg.sv
package eppgi_pkg;
    // Bus geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int GROUPS = 4;
    localparam int GROUP_W = 24;
    // Range sizes in bytes
    localparam int PORT_SPACE_BYTES = 32;
    localparam int CTRL_SPACE_BYTES = 64;
    // Port space offsets
    localparam logic [5:0] OFF_GROUP0 = 6'h00;
    localparam logic [5:0] OFF_GROUP1 = 6'h04;
    localparam logic [5:0] OFF_GROUP2 = 6'h08;
    localparam logic [5:0] OFF_GROUP3 = 6'h0C;
    // Control space offsets
    localparam logic [5:0] OFF_INT_CTRL_STATUS = 6'h38;
    // Group register fields
    localparam int FLD_A_LSB = 0;
    localparam int FLD_B_LSB = 8;
    localparam int FLD_C_LSB = 16;
    localparam int FLD_DIR_LSB = 24;
    localparam int DIR_W = 4;
    localparam int DIR_A = 0;
    localparam int DIR_B = 1;
    localparam int DIR_C_LOW = 2;
    localparam int DIR_C_HIGH = 3;
    // Port C pins used for interrupts in group 3
    localparam int IRQ_GROUP = 3;
    localparam int PIN_REQ = 22;
    localparam int PIN_EN_N = 23;
    // Interrupt control/status fields
    localparam int BIT_POLARITY = 6;
    localparam int BIT_INT_ENABLE = 12;
    localparam int BIT_PENDING = 17;
    localparam int BIT_MISSED = 23;
    // Reset values
    localparam logic [23:0] RST_GROUP_DATA = 24'h000000;
    localparam logic [3:0] RST_GROUP_DIR = 4'h0;
    localparam logic RST_INT_BIT = 1'b0;
    localparam logic [31:0] RST_RDATA = 32'h00000000;
endpackage

// ### src/eppgi_top.sv
//Contract
//- Four group data/direction registers sit at port offsets 0x0..0xC.
//- Writing one to bit 12 at control 0x38 enables interrupt service.
//- Writing ones to bits 17 and 23 clears pending and missed.
//- Ports A, B whole-byte direction; port C nibbles independent.
//- Output bits drive the values written by the host.
//- Input bits capture terminal levels, readable by polling.
//- With bit 12 set, inputs are delivered via the interrupt path.
//- Writing zero to bits 12 and 6 clears enable and polarity.
//- Port register space spans exactly 32 bytes.
//- Control register space spans exactly 64 bytes.
//- Unconnected map jumper selects emulation with the primary map.
//- Accepted interrupt edge sets pending bit 17 and requests service.
//- Edge while pending is ignored and sets the single missed bit.
//- With service on, group 3 port C bits 6/7 are request and enable_n.
//- Interrupt control/status bits reset to zero.
module eppgi_top
    import eppgi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register access, one strobe per access
    input wire logic ctrlSpaceSel,
    input wire logic portSpaceSel,
    input wire logic [5:0] addr,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic rdValid,
    // Map select jumper, high when fitted
    input wire logic mapSelJumper,
    // Port terminals of all groups
    input wire logic [95:0] portIn,
    output logic [95:0] portOut,
    output logic [95:0] portOe,
    // Host interrupt request
    output logic irqReq
);
    logic [23:0] grpData [GROUPS];
    logic [3:0] grpDir [GROUPS];
    logic [23:0] grpSync [GROUPS];
    logic [23:0] snapReg [GROUPS];
    logic [23:0] grpRead [GROUPS];
    logic [GROUPS-1:0] grpWr;
    logic jumperMeta, jumperSync;
    logic polarityReg, intEnableReg, pendingReg, missedReg;
    logic reqPrevReg;
    logic primaryMap, portHit, ctrlHit, ctrlWr;
    logic reqLevel, enLevelN, riseEdge, fallEdge, edgeSeen, accepted;
    logic portAligned, portInRange, freshEdge, missEdge;
    logic clrPending, clrMissed, pendingNext, missedNext;
    logic [31:0] intReadWord, rdataNext;
    logic [1:0] grpIdx;

    ////////////////////////////////////////////////////////////////////////
    // Jumper is a pin, so it is synchronised before use
    // Sampled live: moving the jumper needs no reset, only two clocks
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            jumperMeta <= 1'b0;
            jumperSync <= 1'b0;
        end
        else
        begin
            jumperMeta <= mapSelJumper;
            jumperSync <= jumperMeta;
        end
    end

    // Alternate map is unsupported: with the jumper fitted nothing decodes
    // Writes are dropped there and reads return zero
    assign primaryMap = ~jumperSync;

    ////////////////////////////////////////////////////////////////////////
    // Address decode; port range uses 5 offset bits, control range 6
    // Misaligned or unmapped offsets fall through and read as zero
    assign portAligned = (addr[1:0] == 2'h0);
    // Only the low half of the 32-byte range holds registers
    assign portInRange = (addr[5] == 1'b0) & (addr[4:2] < 3'h4);
    assign portHit = portSpaceSel & primaryMap & portInRange
        & portAligned;
    assign ctrlHit = ctrlSpaceSel & primaryMap
        & (addr == OFF_INT_CTRL_STATUS);
    assign grpIdx = addr[3:2];
    // Control writes need a full decode hit as well as the strobe
    assign ctrlWr = ctrlHit & wrStrobe;

    ////////////////////////////////////////////////////////////////////////
    // Port groups, one instance each
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : gen_group
            assign grpWr[g] = portHit & wrStrobe & (grpIdx == 2'(g));
            // Each group owns its data, direction and input synchroniser
            eppgi_group u_group (
                .clk(clk),
                .arst_n(arst_n),
                .wrEn(grpWr[g]),
                .wdata(wdata),
                .pinIn(portIn[g*GROUP_W +: GROUP_W]),
                .pinOut(portOut[g*GROUP_W +: GROUP_W]),
                .pinOe(portOe[g*GROUP_W +: GROUP_W]),
                .dataReg(grpData[g]),
                .dirReg(grpDir[g]),
                .syncIn(grpSync[g])
            );
            // Polling shows live inputs; interrupt mode shows the latch
            // Group 3 bits six and seven also read the latch in interrupt mode
            assign grpRead[g] = intEnableReg ? snapReg[g] : grpSync[g];
            // Snapshot from the edge that set pending; a miss leaves it
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    snapReg[g] <= {GROUP_W{1'b0}};
                else if (freshEdge)
                    snapReg[g] <= grpSync[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised group 3 port C bit six; bit seven is a level enable
    // Limitation: a request pulse shorter than one clock may be lost
    // Previous level starts at zero, the idle level of an unused input
    assign reqLevel = grpSync[IRQ_GROUP][PIN_REQ];
    assign enLevelN = grpSync[IRQ_GROUP][PIN_EN_N];
    assign riseEdge = reqLevel & ~reqPrevReg;
    assign fallEdge = ~reqLevel & reqPrevReg;
    // Polarity zero selects the rising edge
    // Enable pin is active low and must stay low while edges arrive
    assign edgeSeen = polarityReg ? fallEdge : riseEdge;
    assign accepted = intEnableReg & ~enLevelN & edgeSeen;

    // Write-one clears; a new event in the same cycle wins
    assign clrPending = ctrlWr & wdata[BIT_PENDING];
    assign clrMissed = ctrlWr & wdata[BIT_MISSED];
    // An edge in the cycle of a pending clear starts a new event, no miss
    assign freshEdge = accepted & (~pendingReg | clrPending);
    assign missEdge = accepted & pendingReg & ~clrPending;
    assign pendingNext = accepted | (pendingReg & ~clrPending);
    // One sticky bit only: further misses add nothing
    assign missedNext = missEdge | (missedReg & ~clrMissed);

    // Interrupt control/status state, all clear after reset
    // Host writes load polarity and enable; pending and missed only clear
    // Request mirrors pending from a flop, so the host line never glitches
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            polarityReg <= RST_INT_BIT;
            intEnableReg <= RST_INT_BIT;
            pendingReg <= RST_INT_BIT;
            missedReg <= RST_INT_BIT;
            reqPrevReg <= 1'b0;
            irqReq <= 1'b0;
        end
        else
        begin
            if (ctrlWr)
            begin
                polarityReg <= wdata[BIT_POLARITY];
                intEnableReg <= wdata[BIT_INT_ENABLE];
            end
            pendingReg <= pendingNext;
            missedReg <= missedNext;
            reqPrevReg <= reqLevel;
            irqReq <= pendingNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: output bits return written data, input bits the pins when polling, the latch in interrupt mode
    // Group word layout:
    //   [23:0]  data bytes, port A lowest, port C highest
    //   [27:24] direction of A, B, C low nibble, C high nibble
    //   [31:28] always zero
    // Limitation: no byte enables, every access moves a whole word
    function automatic logic [31:0] groupWord(input logic [23:0] data,
        input logic [3:0] dir, input logic [23:0] pins);
        logic [23:0] oe;
        oe = {{4{dir[DIR_C_HIGH]}}, {4{dir[DIR_C_LOW]}},
            {8{dir[DIR_B]}}, {8{dir[DIR_A]}}};
        groupWord = {4'h0, dir, (oe & data) | (~oe & pins)};
    endfunction

    // Interrupt word: four defined bits, every other bit reads zero
    // Pending and missed read back whether or not service is enabled
    assign intReadWord = ({31'h0, polarityReg} << BIT_POLARITY)
        | ({31'h0, intEnableReg} << BIT_INT_ENABLE)
        | ({31'h0, pendingReg} << BIT_PENDING)
        | ({31'h0, missedReg} << BIT_MISSED);
    // Unmapped offsets in either range read as zero
    assign rdataNext = portHit
        ? groupWord(grpData[grpIdx], grpDir[grpIdx], grpRead[grpIdx])
        : (ctrlHit ? intReadWord : 32'h00000000);

    // Read answer registered one cycle after the strobe
    // Every read answers, even unmapped or blocked, so the host never stalls
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= RST_RDATA;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= rdStrobe;
            if (rdStrobe)
                rdata <= rdataNext;
        end
    end
endmodule
